// [design/flash_int_pkg.sv]
package flash_int_pkg;

  // ==========================================================================
  // Serial commands
  localparam logic [7:0] OP_READ_ANY = 8'h65;
  localparam logic [7:0] OP_WRITE_ANY = 8'h71;
  localparam logic [7:0] OP_CLEAR_ECC = 8'h1B;

  // ==========================================================================
  // Register addresses carried by the generic register commands
  localparam logic [23:0] ADDR_MASK_CONFIG = 24'h000010;
  localparam logic [23:0] ADDR_EVENT_FLAGS = 24'h000011;

  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CONFIG = 2'h1;
  localparam logic [1:0] SEL_FLAGS = 2'h2;

  // ==========================================================================
  // Field layout and reset values
  localparam int BIT_OUT_ENABLE = 7;
  localparam logic [7:0] READY_MASK = 8'h10;
  localparam logic [7:0] DOUBLE_MASK = 8'h02;
  localparam logic [7:0] SINGLE_MASK = 8'h01;
  localparam logic [7:0] SOURCE_MASK = 8'h13;
  localparam logic [7:0] ECC_MASK = 8'h03;
  localparam logic [7:0] CONFIG_WRITABLE = 8'h93;
  localparam logic [7:0] CONFIG_RESET = 8'hFF;
  localparam logic [7:0] FLAGS_RESET = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;

  // ==========================================================================
  // Serial framing counts
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  localparam logic [2:0] QUAD_LAST_BIT = 3'h4;
  localparam logic [2:0] SPI_STEP = 3'h1;
  localparam logic [2:0] QUAD_STEP = 3'h4;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [3:0] SPI_OUT_OE = 4'h2;
  localparam logic [3:0] QUAD_OUT_OE = 4'hF;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } xfer_state_t;

endpackage : flash_int_pkg

// [design/flash_interrupt_logic.sv]
`timescale 1ns/100ps

// Notes on behaviour
// - Enabled events pull the open-drain active-low interrupt pin low.
// - Config bit 7 high keeps the pin released; low lets events drive it.
// - Pin low only when a flag is low and its own enable is low.
// - Config bit 4 low lets a busy-to-ready transition pull the pin.
// - Config bit 1 low lets a double-bit ECC event pull the pin.
// - Config bit 0 low lets a single-bit ECC event pull the pin.
// - Writing the config register never changes the event flags.
// - Flags latch on their event regardless of masks and hold until cleared.
// - Flag bit 4 reads 0 after a busy-to-ready transition since last clear.
// - Flag bit 1 goes 0 on a double-bit error during a user read.
// - Flag bit 0 goes 0 on a single-bit correction during a user read.
// - ECC events from program or scrub routines do not touch the flags.
// - Writing 1 to a low flag bit returns it to 1.
// - Pin is released once every low flag is reset or masked, or config bit 7 is set.
// - Writing 1 to config bit 7 releases an asserted pin.
// - The clear-ECC command resets both ECC flags to 1.
// - Hardware and software reset return all flags to 1.
// - Both registers are read and written by the generic commands, SPI and quad.
module flash_interrupt_logic (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic softReset,
  input wire logic busy,
  input wire logic singleErrorEvent,
  input wire logic doubleErrorEvent,
  input wire logic userReadAccess,
  input wire logic quadCommandMode,
  input wire logic csN,
  input wire logic sck,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  output logic intOut,
  output logic intOe
);

  // ==========================================================================
  // Address decode, shared by the read and write paths
  function automatic logic [1:0] decodeAddr(input logic [23:0] addr);
    if (addr == flash_int_pkg::ADDR_MASK_CONFIG) begin
      return flash_int_pkg::SEL_CONFIG;
    end else if (addr == flash_int_pkg::ADDR_EVENT_FLAGS) begin
      return flash_int_pkg::SEL_FLAGS;
    end else begin
      return flash_int_pkg::SEL_NONE;
    end
  endfunction : decodeAddr

  // ==========================================================================
  // Pin synchronisers; serial clock runs far slower than clk
  logic [1:0] csSync_q;
  logic [1:0] sckSync_q;
  logic [3:0] ioSyncA_q;
  logic [3:0] ioSyncB_q;
  logic sckPrev_q;

  // Select resets to deselected so no frame starts while the pin settles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csSync_q <= 2'h3;
    end else begin
      csSync_q <= {csSync_q[0], csN};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sckSync_q <= 2'h0;
    end else begin
      sckSync_q <= {sckSync_q[0], sck};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ioSyncA_q <= 4'h0;
      ioSyncB_q <= 4'h0;
    end else begin
      ioSyncA_q <= ioIn;
      ioSyncB_q <= ioSyncA_q;
    end
  end

  // Matches the idle low clock so no false edge follows reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sckPrev_q <= 1'b0;
    end else begin
      sckPrev_q <= sckSync_q[1];
    end
  end

  logic selected;
  logic sckRise;
  logic sckFall;
  assign selected = !csSync_q[1];
  assign sckRise = selected && sckSync_q[1] && !sckPrev_q;
  assign sckFall = selected && !sckSync_q[1] && sckPrev_q;

  // ==========================================================================
  // Command framing, mode 0, MSB first
  flash_int_pkg::xfer_state_t state_q;
  flash_int_pkg::xfer_state_t state_d;
  logic [2:0] bitCnt_q;
  logic [1:0] addrCnt_q;
  logic [7:0] shiftIn_q;
  logic [23:0] addr_q;
  logic opIsWrite_q;

  logic [2:0] step;
  logic [2:0] lastBit;
  logic [7:0] newByte;
  logic byteDone;
  logic addrDone;
  assign step = quadCommandMode ? flash_int_pkg::QUAD_STEP : flash_int_pkg::SPI_STEP;
  assign lastBit = quadCommandMode ? flash_int_pkg::QUAD_LAST_BIT : flash_int_pkg::SPI_LAST_BIT;
  assign newByte = quadCommandMode ? {shiftIn_q[3:0], ioSyncB_q} : {shiftIn_q[6:0], ioSyncB_q[0]};
  assign byteDone = sckRise && (bitCnt_q == lastBit);
  assign addrDone = byteDone && (state_q == flash_int_pkg::ST_ADDR) &&
                    (addrCnt_q == flash_int_pkg::ADDR_LAST_BYTE);

  logic opcodeDone;
  logic addrByteDone;
  assign opcodeDone = byteDone && (state_q == flash_int_pkg::ST_OPCODE);
  assign addrByteDone = byteDone && (state_q == flash_int_pkg::ST_ADDR);

  always_comb begin
    state_d = state_q;
    if (byteDone) begin
      case (state_q)
        flash_int_pkg::ST_OPCODE: begin
          if ((newByte == flash_int_pkg::OP_READ_ANY) ||
              (newByte == flash_int_pkg::OP_WRITE_ANY)) begin
            state_d = flash_int_pkg::ST_ADDR;
          end else begin
            state_d = flash_int_pkg::ST_IGNORE;
          end
        end
        flash_int_pkg::ST_ADDR: begin
          if (addrCnt_q == flash_int_pkg::ADDR_LAST_BYTE) begin
            state_d = opIsWrite_q ? flash_int_pkg::ST_WDATA : flash_int_pkg::ST_RDATA;
          end
        end
        flash_int_pkg::ST_WDATA: begin
          state_d = flash_int_pkg::ST_IGNORE;
        end
        flash_int_pkg::ST_RDATA: begin
          state_d = flash_int_pkg::ST_RDATA;
        end
        default: begin
          state_d = flash_int_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= flash_int_pkg::ST_OPCODE;
    end else if (!selected) begin
      state_q <= flash_int_pkg::ST_OPCODE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_q <= 3'h0;
    end else if (!selected) begin
      bitCnt_q <= 3'h0;
    end else if (sckRise) begin
      bitCnt_q <= bitCnt_q + step;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addrCnt_q <= 2'h0;
    end else if (!selected) begin
      addrCnt_q <= 2'h0;
    end else if (addrByteDone) begin
      addrCnt_q <= addrCnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftIn_q <= 8'h00;
    end else if (sckRise) begin
      shiftIn_q <= newByte;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 24'h000000;
    end else if (addrByteDone) begin
      addr_q <= {addr_q[15:0], newByte};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opIsWrite_q <= 1'b0;
    end else if (opcodeDone) begin
      opIsWrite_q <= (newByte == flash_int_pkg::OP_WRITE_ANY);
    end
  end

  // ==========================================================================
  // Register access strobes
  logic [1:0] regSel;
  logic wrStrobe;
  logic writeConfig;
  logic writeFlags;
  logic clearEcc;
  assign regSel = decodeAddr(addr_q);
  assign wrStrobe = byteDone && (state_q == flash_int_pkg::ST_WDATA);
  assign writeConfig = wrStrobe && (regSel == flash_int_pkg::SEL_CONFIG);
  assign writeFlags = wrStrobe && (regSel == flash_int_pkg::SEL_FLAGS);
  // Acts as the opcode completes rather than at deselect, to keep framing simple
  assign clearEcc = byteDone && (state_q == flash_int_pkg::ST_OPCODE) &&
                    (newByte == flash_int_pkg::OP_CLEAR_ECC);

  // ==========================================================================
  // Interrupt registers
  logic [7:0] maskConfig_q;
  logic [7:0] maskConfig_d;
  logic [7:0] eventFlags_q;
  logic [7:0] eventFlags_d;
  logic busyPrev_q;
  logic readyEvent;
  logic [7:0] eventSet;
  logic [7:0] flagRelease;

  assign readyEvent = busyPrev_q && !busy;
  assign eventSet = ({8{readyEvent}} & flash_int_pkg::READY_MASK) |
                    ({8{doubleErrorEvent && userReadAccess}} & flash_int_pkg::DOUBLE_MASK) |
                    ({8{singleErrorEvent && userReadAccess}} & flash_int_pkg::SINGLE_MASK);
  assign flagRelease = ({8{writeFlags}} & newByte & flash_int_pkg::SOURCE_MASK) |
                       ({8{clearEcc}} & flash_int_pkg::ECC_MASK);
  // An event in the same cycle as its clear still wins
  assign eventFlags_d = softReset ? flash_int_pkg::FLAGS_RESET :
                        (eventFlags_q | flagRelease) & ~eventSet;
  assign maskConfig_d = softReset ? flash_int_pkg::CONFIG_RESET :
                        writeConfig ? ((newByte & flash_int_pkg::CONFIG_WRITABLE) |
                                       ~flash_int_pkg::CONFIG_WRITABLE) :
                        maskConfig_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      maskConfig_q <= flash_int_pkg::CONFIG_RESET;
    end else begin
      maskConfig_q <= maskConfig_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eventFlags_q <= flash_int_pkg::FLAGS_RESET;
    end else begin
      eventFlags_q <= eventFlags_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busyPrev_q <= 1'b0;
    end else begin
      busyPrev_q <= busy;
    end
  end

  // ==========================================================================
  // Interrupt pin, open drain: only ever drives low
  logic [7:0] pending;
  logic intActive;
  logic intOe_q;
  assign pending = ~eventFlags_q & ~maskConfig_q & flash_int_pkg::SOURCE_MASK;
  assign intActive = !maskConfig_q[flash_int_pkg::BIT_OUT_ENABLE] && (|pending);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intOe_q <= 1'b0;
    end else begin
      intOe_q <= intActive;
    end
  end

  assign intOut = 1'b0;
  assign intOe = intOe_q;

  // ==========================================================================
  // Read data path; byte is loaded on the falling edge after the address
  logic [7:0] readValue;
  logic [7:0] shiftOut_q;
  logic loadPending_q;
  logic driving_q;
  logic [7:0] rotated;

  assign readValue = (regSel == flash_int_pkg::SEL_CONFIG) ? maskConfig_q :
                     (regSel == flash_int_pkg::SEL_FLAGS) ? eventFlags_q :
                     flash_int_pkg::UNMAPPED_READ;
  assign rotated = quadCommandMode ? {shiftOut_q[3:0], shiftOut_q[7:4]} :
                   {shiftOut_q[6:0], shiftOut_q[7]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loadPending_q <= 1'b0;
    end else if (!selected) begin
      loadPending_q <= 1'b0;
    end else if (addrDone && !opIsWrite_q) begin
      loadPending_q <= 1'b1;
    end else if (sckFall) begin
      loadPending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      driving_q <= 1'b0;
    end else if (!selected) begin
      driving_q <= 1'b0;
    end else if (sckFall && loadPending_q) begin
      driving_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftOut_q <= 8'hFF;
    end else if (sckFall && loadPending_q) begin
      shiftOut_q <= readValue;
    end else if (sckFall && driving_q) begin
      shiftOut_q <= rotated;
    end
  end

  // Repeated clocks keep returning the same byte
  assign ioOut = quadCommandMode ? shiftOut_q[7:4] : {2'b00, shiftOut_q[7], 1'b0};
  assign ioOe = !driving_q ? 4'h0 :
                quadCommandMode ? flash_int_pkg::QUAD_OUT_OE : flash_int_pkg::SPI_OUT_OE;

endmodule : flash_interrupt_logic

// [testbench/flash_int_asserts.sv]
`timescale 1ns/100ps
module flash_int_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic softReset,
  input wire logic busy,
  input wire logic singleErrorEvent,
  input wire logic doubleErrorEvent,
  input wire logic userReadAccess,
  input wire logic quadCommandMode,
  input wire logic csN,
  input wire logic sck,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  input wire logic intOut,
  input wire logic intOe
);
  // ==========
  // Cause ages: a register write lands a few clocks after its last bit
  logic [3:0] riseAge_q;
  logic [3:0] fallAge_q;
  logic busy_q;
  wire eccCause = userReadAccess && (singleErrorEvent || doubleErrorEvent);
  wire riseCause = !csN || (busy_q && !busy) || eccCause;
  wire fallCause = !csN || softReset;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      riseAge_q <= 4'hF;
      fallAge_q <= 4'hF;
      busy_q <= 1'b0;
    end else begin
      riseAge_q <= riseCause ? 4'h0 : riseAge_q + {3'h0, riseAge_q != 4'hF};
      fallAge_q <= fallCause ? 4'h0 : fallAge_q + {3'h0, fallAge_q != 4'hF};
      busy_q <= busy;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_pin_open_drain: assert property (intOut == 1'b0)
    else $error("interrupt pin driven high");
  chk_rise_has_cause: assert property ($rose(intOe) |-> riseAge_q <= 4'h6)
    else $error("interrupt rose without event or write");
  chk_fall_has_cause: assert property ($fell(intOe) |-> fallAge_q <= 4'h8)
    else $error("interrupt released without clear");
  chk_soft_release: assert property (softReset |-> ##2 !intOe)
    else $error("interrupt held after soft reset");
  chk_reset_quiet: assert property ($rose(reset_n) |-> !intOe [*4])
    else $error("interrupt active after reset");
  chk_idle_released: assert property (csN [*4] |-> ioOe == 4'h0)
    else $error("data pins driven while deselected");
  chk_lane_width: assert property (ioOe != 4'h0 |-> ioOe == (quadCommandMode ? 4'hF : 4'h2))
    else $error("wrong data lanes driven");
  chk_out_steady: assert property (($stable(sck) && $stable(csN) && $stable(quadCommandMode)) [*6]
    |-> $stable(ioOut) && $stable(ioOe))
    else $error("read data moved without a clock");
endmodule : flash_int_asserts
bind flash_interrupt_logic flash_int_asserts u_chk (.clk(clk), .reset_n(reset_n),
  .softReset(softReset), .busy(busy), .singleErrorEvent(singleErrorEvent),
  .doubleErrorEvent(doubleErrorEvent), .userReadAccess(userReadAccess),
  .quadCommandMode(quadCommandMode), .csN(csN), .sck(sck), .ioOut(ioOut),
  .ioOe(ioOe), .intOut(intOut), .intOe(intOe));

// [testbench/host_link.sv]
`timescale 1ns/100ps
module host_link (
  input wire logic clk,
  input wire logic quadCommandMode,
  input wire logic [3:0] ioOut,
  output logic csN,
  output logic sck,
  output logic [3:0] ioIn
);
  // ==========
  // Host side of the register link, mode 0, clock idles low
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    ioIn = 4'h0;
  end
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    int n;
    n = quadCommandMode ? 2 : 8;
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      ioIn <= quadCommandMode ? tx[7 - 4 * i -: 4] : {{3{~tx[7 - i]}}, tx[7 - i]};
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      rx = quadCommandMode ? {rx[3:0], ioOut} : {rx[6:0], ioOut[1]};
      sck <= 1'b0;
    end
  endtask : shift
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] wd,
                       output logic [7:0] rd);
    csN <= 1'b0;
    shift(op, rd);
    if (op != flash_int_pkg::OP_CLEAR_ECC) begin
      for (int b = 2; b >= 0; b--) shift(addr[8 * b +: 8], rd);
      shift(wd, rd);
    end
    repeat (4) @(posedge clk);
    csN <= 1'b1;
    // Released lines keep moving so a stale value is never trusted
    ioIn <= ~ioIn;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : host_link

// [testbench/flash_interrupt_logic_bench.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin badCount++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module flash_interrupt_logic_bench;
  localparam logic [23:0] CFG = flash_int_pkg::ADDR_MASK_CONFIG;
  localparam logic [23:0] FLG = flash_int_pkg::ADDR_EVENT_FLAGS;
  logic clk, reset_n, softReset, busy, singleErrorEvent, doubleErrorEvent;
  logic userReadAccess, quadCommandMode, csN, sck, intOut, intOe;
  logic [3:0] ioIn, ioOut, ioOe;
  logic [7:0] r;
  int badCount = 0;
  int compares = 0;
  flash_interrupt_logic u_dut (.clk(clk), .reset_n(reset_n), .softReset(softReset),
    .busy(busy), .singleErrorEvent(singleErrorEvent), .doubleErrorEvent(doubleErrorEvent),
    .userReadAccess(userReadAccess), .quadCommandMode(quadCommandMode), .csN(csN),
    .sck(sck), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .intOut(intOut), .intOe(intOe));
  host_link u_host (.clk(clk), .quadCommandMode(quadCommandMode), .ioOut(ioOut),
    .csN(csN), .sck(sck), .ioIn(ioIn));
  // ==========
  // Access helpers
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    u_host.frame(flash_int_pkg::OP_WRITE_ANY, a, d, r);
  endtask : wr
  task automatic rdChk(input string n, input logic [23:0] a, input logic [7:0] e);
    u_host.frame(flash_int_pkg::OP_READ_ANY, a, 8'h5A, r);
    `CHK(n, e, r)
  endtask : rdChk
  task automatic ev(input logic s, input logic d, input logic u);
    singleErrorEvent <= s;
    doubleErrorEvent <= d;
    userReadAccess <= u;
    @(posedge clk);
    singleErrorEvent <= 1'b0;
    doubleErrorEvent <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ev
  // ==========
  // Scenarios
  task automatic resetValues;
    for (int m = 0; m < 2; m++) begin
      quadCommandMode <= m[0];
      @(posedge clk);
      rdChk("config", CFG, 8'hFF);
      rdChk("flags", FLG, 8'hFF);
      rdChk("unmapped", 24'h000000, 8'hFF);
    end
    quadCommandMode <= 1'b0;
    @(posedge clk);
  endtask : resetValues
  task automatic readyEvent;
    wr(CFG, 8'h10);
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("masked ready", 1'b0, intOe)
    rdChk("flags", FLG, 8'hEF);
    wr(CFG, 8'h00);
    `CHK("ready int", 1'b1, intOe)
    rdChk("config", CFG, 8'h6C);
    rdChk("flags", FLG, 8'hEF);
    wr(CFG, 8'h80);
    `CHK("output off", 1'b0, intOe)
    wr(CFG, 8'h00);
    wr(FLG, 8'h10);
    `CHK("cleared", 1'b0, intOe)
    rdChk("flags", FLG, 8'hFF);
  endtask : readyEvent
  task automatic eccEvents;
    ev(1'b1, 1'b1, 1'b0);
    rdChk("flags", FLG, 8'hFF);
    ev(1'b1, 1'b0, 1'b1);
    `CHK("single int", 1'b1, intOe)
    ev(1'b0, 1'b1, 1'b1);
    rdChk("flags", FLG, 8'hFC);
    wr(FLG, 8'h01);
    `CHK("int held", 1'b1, intOe)
    rdChk("flags", FLG, 8'hFD);
    u_host.frame(flash_int_pkg::OP_CLEAR_ECC, 24'h000000, 8'h00, r);
    `CHK("ecc cleared", 1'b0, intOe)
    rdChk("flags", FLG, 8'hFF);
    wr(CFG, 8'h03);
    ev(1'b1, 1'b1, 1'b1);
    `CHK("masked ecc", 1'b0, intOe)
    rdChk("flags", FLG, 8'hFC);
    wr(CFG, 8'h00);
    `CHK("unmasked ecc", 1'b1, intOe)
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("soft released", 1'b0, intOe)
    rdChk("config", CFG, 8'hFF);
    rdChk("flags", FLG, 8'hFF);
  endtask : eccEvents
  task automatic quadAccess;
    quadCommandMode <= 1'b1;
    @(posedge clk);
    wr(CFG, 8'h12);
    rdChk("quad config", CFG, 8'h7E);
    ev(1'b1, 1'b0, 1'b1);
    `CHK("quad int", 1'b1, intOe)
    rdChk("quad flags", FLG, 8'hFE);
    wr(FLG, 8'h01);
    `CHK("quad released", 1'b0, intOe)
    rdChk("quad cleared", FLG, 8'hFF);
    wr(CFG, 8'h00);
    quadCommandMode <= 1'b0;
    @(posedge clk);
  endtask : quadAccess
  task automatic midReset;
    wr(CFG, 8'h00);
    ev(1'b1, 1'b0, 1'b1);
    `CHK("int before reset", 1'b1, intOe)
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("int in reset", 1'b0, intOe)
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdChk("config", CFG, 8'hFF);
    rdChk("flags", FLG, 8'hFF);
  endtask : midReset
  task automatic conclude;
    $display("Compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    badCount++;
    conclude();
  end
  initial begin
    reset_n = 1'b0;
    softReset = 1'b0;
    busy = 1'b0;
    singleErrorEvent = 1'b0;
    doubleErrorEvent = 1'b0;
    userReadAccess = 1'b0;
    quadCommandMode = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    resetValues();
    readyEvent();
    quadAccess();
    eccEvents();
    midReset();
    conclude();
  end
endmodule : flash_interrupt_logic_bench
